// ### rtl/spd_engine.sv
// Eight-channel transfer engine between serial peripherals and system memory.
`timescale 1ns/10ps
module spd_engine
    import spd_pkg::*;
#(
    parameter logic [NUM_PERIPH-1:0][31:0] PERIPH_BASE =
        {BASE_SPI, BASE_USART2, BASE_USART1, BASE_USART0}
) (
    input  wire logic                                clk,        // System clock, 20 MHz.
    input  wire logic                                sys_rst,    // Synchronous reset, high.
    input  wire logic [31:0]                         reg_addr,   // Register byte address.
    input  wire logic                                reg_wr,     // Register write strobe.
    input  wire logic                                reg_rd,     // Register read strobe.
    input  wire logic [31:0]                         reg_wdata,  // Register write data.
    output logic      [31:0]                         reg_rdata,  // Read data, next cycle.
    output logic                                     reg_hit,    // Address maps to a channel.
    input  wire logic [spd_pkg::NUM_PERIPH-1:0]      item_half,  // Peripheral items are 16-bit.
    input  wire logic [spd_pkg::NUM_PERIPH-1:0]      rx_ready,   // Received item waiting.
    input  wire logic [spd_pkg::NUM_PERIPH-1:0][15:0] rx_item,   // Received item value.
    output logic      [spd_pkg::NUM_PERIPH-1:0]      rx_taken,   // Received item consumed.
    input  wire logic [spd_pkg::NUM_PERIPH-1:0]      tx_space,   // Transmit holding free.
    output logic      [spd_pkg::ITEM_W-1:0]          tx_item,    // Item for the transmitter.
    output logic      [spd_pkg::NUM_PERIPH-1:0]      tx_load,    // Load tx_item, one cycle.
    output logic      [spd_pkg::NUM_CH-1:0]          xfer_end,   // Count of channel is zero.
    output logic      [spd_pkg::NUM_CH-1:0]          xfer_done,  // Last item moved, pulse.
    output logic                                     mem_req,    // Memory access pending.
    output logic                                     mem_we,     // Memory write.
    output logic      [31:0]                         mem_addr,   // Memory byte address.
    output logic      [3:0]                          mem_be,     // Byte lanes.
    output logic      [31:0]                         mem_wdata,  // Memory write data.
    input  wire logic                                mem_ack,    // Access complete.
    input  wire logic [31:0]                         mem_rdata   // Memory read data.
);
    import spd_pkg::*;

    typedef struct packed {
        logic [NUM_CH-1:0][PTR_W-1:0] ptr;
        logic [NUM_CH-1:0][CNT_W-1:0] cnt;
        spd_state_e                   st;
        logic [CH_W-1:0]              ch;
        logic [31:0]                  maddr;
        logic [31:0]                  mwdata;
        logic [3:0]                   mbe;
        logic [ITEM_W-1:0]            txd;
        logic [NUM_PERIPH-1:0]        rx_take;
        logic [NUM_PERIPH-1:0]        tx_ld;
        logic [NUM_CH-1:0]            done;
        logic [31:0]                  rdata;
    } spd_q_s;

    spd_q_s q;
    spd_q_s next_q;

    // Decode an address into {hit, channel, count-select}; used for reads and writes.
    function automatic logic [4:0] reg_decode(input logic [31:0] a);
        logic [4:0] r;
        r = 5'h00;
        for (int p = 0; p < NUM_PERIPH; p++) begin
            if (a >= TOP_REGION && a[31:WIN_W] == PERIPH_BASE[p][31:WIN_W]) begin
                unique case (a[WIN_W-1:0])
                    OFS_RX_PTR: r = {1'b1, PER_W'(p), 1'b0, 1'b0};
                    OFS_RX_CNT: r = {1'b1, PER_W'(p), 1'b0, 1'b1};
                    OFS_TX_PTR: r = {1'b1, PER_W'(p), 1'b1, 1'b0};
                    OFS_TX_CNT: r = {1'b1, PER_W'(p), 1'b1, 1'b1};
                    default:    r = r;
                endcase
            end
        end
        return r;
    endfunction

    logic [4:0]       wdec;
    logic [4:0]       rdec;
    logic [31:0]      step_cur;
    logic [PTR_W-1:0] ptr_cur;
    logic [CNT_W-1:0] cnt_cur;
    logic             wr_cur;

    assign wdec     = reg_decode(reg_addr);
    assign rdec     = wdec;
    assign reg_hit  = wdec[4];
    assign step_cur = item_half[q.ch[CH_W-1:1]] ? 32'h0000_0002 : 32'h0000_0001;
    assign ptr_cur  = q.ptr[q.ch];
    assign cnt_cur  = q.cnt[q.ch];
    assign wr_cur   = reg_wr && wdec[4] && wdec[3:1] == q.ch;

    // Next-state logic: arbitration, memory sequencing and software access.
    always_comb begin
        logic [NUM_CH-1:0] elig;
        logic [CH_W-1:0]   gch;
        logic              found;
        logic [PER_W-1:0]  gp;
        logic [15:0]       item;
        logic [31:0]       shifted;
        elig    = '0;
        gch     = '0;
        found   = 1'b0;
        gp      = '0;
        item    = '0;
        shifted = '0;
        next_q         = q;
        next_q.rx_take = '0;
        next_q.tx_ld   = '0;
        next_q.done    = '0;
        // Channels whose last handshake is still visible are masked so that the
        // peripheral gets one cycle to drop its ready before being served again.
        for (int i = 0; i < NUM_CH; i++) begin
            if (i % 2 == 0) begin
                elig[i] = q.cnt[i] != CNT_RST && rx_ready[i/2] && !q.rx_take[i/2];
            end else begin
                elig[i] = q.cnt[i] != CNT_RST && tx_space[i/2] && !q.tx_ld[i/2];
            end
        end
        // Fixed priority: lower channel numbers win.
        for (int i = NUM_CH - 1; i >= 0; i--) begin
            if (elig[i]) begin
                gch   = CH_W'(i);
                found = 1'b1;
            end
        end
        gp = gch[CH_W-1:1];
        unique case (q.st)
            ST_IDLE: begin
                if (found) begin
                    next_q.ch    = gch;
                    next_q.maddr = q.ptr[gch];
                    if (!gch[0]) begin
                        next_q.st          = ST_WR;
                        next_q.rx_take[gp] = 1'b1;
                        item               = rx_item[gp];
                        next_q.mwdata      = item_half[gp] ? {2{item}} : {4{item[7:0]}};
                    end else begin
                        next_q.st = ST_RD;
                    end
                    if (item_half[gp]) begin
                        next_q.mbe = q.ptr[gch][1] ? BE_HALF1 : BE_HALF0;
                    end else begin
                        next_q.mbe = 4'(BE_BYTE0 << q.ptr[gch][1:0]);
                    end
                end
            end
            ST_WR, ST_RD: begin
                if (mem_ack) begin
                    // Full 32-bit add keeps a 64K-byte run contiguous across any boundary.
                    next_q.ptr[q.ch] = q.ptr[q.ch] + step_cur;
                    next_q.cnt[q.ch] = q.cnt[q.ch] - 16'h0001;
                    next_q.done[q.ch] = q.cnt[q.ch] == 16'h0001;
                    next_q.st = ST_IDLE;
                    if (q.st == ST_RD) begin
                        shifted = mem_rdata >> {q.maddr[1:0], 3'b000};
                        next_q.txd = item_half[q.ch[CH_W-1:1]] ? shifted[15:0]
                                                                : {8'h00, shifted[7:0]};
                        next_q.tx_ld[q.ch[CH_W-1:1]] = 1'b1;
                    end
                end
            end
            default: next_q.st = ST_IDLE;
        endcase
        // Software writes land last, so reprogramming beats a completing item.
        if (reg_wr && wdec[4]) begin
            if (wdec[0]) begin
                next_q.cnt[wdec[3:1]] = reg_wdata[CNT_W-1:0];
            end else begin
                next_q.ptr[wdec[3:1]] = reg_wdata;
            end
        end
        // Reads return zero for addresses outside every channel register.
        if (reg_rd) begin
            if (!rdec[4]) begin
                next_q.rdata = 32'h0000_0000;
            end else if (rdec[0]) begin
                next_q.rdata = {16'h0000, q.cnt[rdec[3:1]]};
            end else begin
                next_q.rdata = q.ptr[rdec[3:1]];
            end
        end
    end

    // State register.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            q    <= '0;
            q.st <= ST_IDLE;
        end else begin
            q <= next_q;
        end
    end

    // Outputs.
    assign reg_rdata = q.rdata;
    assign rx_taken  = q.rx_take;
    assign tx_item   = q.txd;
    assign tx_load   = q.tx_ld;
    assign xfer_done = q.done;
    assign mem_req   = q.st != ST_IDLE;
    assign mem_we    = q.st == ST_WR;
    assign mem_addr  = q.maddr;
    assign mem_be    = q.mbe;
    assign mem_wdata = q.mwdata;

    // End-of-transfer level per channel for the owning peripheral's interrupt.
    for (genvar c = 0; c < NUM_CH; c++) begin : g_end
        assign xfer_end[c] = q.cnt[c] == CNT_RST;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence s_ack;
        mem_req && mem_ack && !wr_cur;
    endsequence

    property p_cnt_dec;
        s_ack |=> cnt_cur == $past(cnt_cur) - 16'h0001;
    endproperty
    a_cnt_dec: assert property (p_cnt_dec) else $error("count did not drop by one");

    property p_ptr_adv;
        s_ack |=> ptr_cur == $past(ptr_cur) + $past(step_cur);
    endproperty
    a_ptr_adv: assert property (p_ptr_adv) else $error("pointer did not advance");

    property p_start_ok;
        (q.st == ST_IDLE) ##1 (q.st != ST_IDLE) |-> $past(q.cnt[next_q.ch]) != CNT_RST;
    endproperty
    a_start_ok: assert property (p_start_ok) else $error("started with zero count");

    property p_rx_flow;
        (|rx_taken) |-> mem_req && mem_we && !q.ch[0] && rx_taken[q.ch[CH_W-1:1]];
    endproperty
    a_rx_flow: assert property (p_rx_flow) else $error("receive take without write");

    property p_done_end;
        xfer_done[q.ch] |-> xfer_end[q.ch] && $past(mem_ack) && !mem_req;
    endproperty
    a_done_end: assert property (p_done_end) else $error("done without empty count");

    property p_byte_lane;
        mem_req && !item_half[q.ch[CH_W-1:1]] |-> mem_be == 4'(BE_BYTE0 << mem_addr[1:0]);
    endproperty
    a_byte_lane: assert property (p_byte_lane) else $error("wrong byte lane");

    property p_tx_load;
        (|tx_load) |-> $past(mem_req && mem_ack && !mem_we) && q.ch[0];
    endproperty
    a_tx_load: assert property (p_tx_load) else $error("transmit load without read");

    property p_reg_read;
        reg_rd && reg_hit && wdec[0] && !reg_wr |=> reg_rdata[31:16] == 16'h0000;
    endproperty
    a_reg_read: assert property (p_reg_read) else $error("count read not zero-padded");

    property p_sw_write;
        reg_wr && reg_hit && !wdec[0] |=> q.ptr[$past(wdec[3:1])] == $past(reg_wdata);
    endproperty
    a_sw_write: assert property (p_sw_write) else $error("pointer write lost");

endmodule

// ### rtl/spd_pkg.sv
// Shared constants and types for the serial peripheral transfer channels.
package spd_pkg;

    // Channel population: two channels per served peripheral.
    localparam int NUM_PERIPH = 4;
    localparam int NUM_CH     = 2 * NUM_PERIPH;
    localparam int CH_W       = 3;
    localparam int PER_W      = 2;

    // Register widths.
    localparam int PTR_W  = 32;
    localparam int CNT_W  = 16;
    localparam int ITEM_W = 16;

    // Peripheral windows: 16K bytes each, inside the top 3M bytes of the map.
    localparam int          WIN_W        = 14;
    localparam logic [31:0] TOP_REGION   = 32'hFFD0_0000;
    localparam logic [31:0] BASE_USART0  = 32'hFFFC_0000;
    localparam logic [31:0] BASE_USART1  = 32'hFFFC_4000;
    localparam logic [31:0] BASE_USART2  = 32'hFFFC_8000;
    localparam logic [31:0] BASE_SPI     = 32'hFFFB_C000;

    // Channel register offsets inside each peripheral window.
    localparam logic [13:0] OFS_RX_PTR = 14'h0030;
    localparam logic [13:0] OFS_RX_CNT = 14'h0034;
    localparam logic [13:0] OFS_TX_PTR = 14'h0038;
    localparam logic [13:0] OFS_TX_CNT = 14'h003C;

    // Reset values.
    localparam logic [PTR_W-1:0] PTR_RST = 32'h0000_0000;
    localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;

    // Memory lane patterns, little-endian.
    localparam logic [3:0] BE_BYTE0 = 4'h1;
    localparam logic [3:0] BE_HALF0 = 4'h3;
    localparam logic [3:0] BE_HALF1 = 4'hC;

    // Engine states, one-hot.
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_WR   = 3'b010,
        ST_RD   = 3'b100
    } spd_state_e;

endpackage

// ### tb/spd_mem_model.sv
// Behavioural system memory that answers the engine's accesses after a random wait.
`timescale 1ns/10ps
module spd_mem_model (
    input  wire logic        clk,       // System clock.
    input  wire logic        mem_req,   // Access pending from the engine.
    input  wire logic [31:0] mem_addr,  // Byte address of the access.
    output logic             mem_ack,   // One-cycle completion.
    output logic      [31:0] mem_rdata  // Read data, valid with mem_ack only.
);
    int wait_n;

    // Read data is a pattern of the address; it toggles every idle cycle and after each answer (it holds during a wait),
    // so a design that samples it at the wrong edge cannot get lucky.
    initial begin
        mem_ack   = 1'b0;
        mem_rdata = 32'h0000_0000;
        forever begin
            @(posedge clk);
            if (mem_req === 1'b1) begin
                wait_n = $urandom % 3;
                repeat (wait_n) @(posedge clk);
                #2;
                mem_ack   = 1'b1;
                mem_rdata = {mem_addr[15:0] ^ 16'h5A3C, mem_addr[15:0] ^ 16'hC3A5};
                @(posedge clk);
                #2;
                mem_ack   = 1'b0;
                mem_rdata = ~mem_rdata;
            end else begin
                #2 mem_rdata = ~mem_rdata;
            end
        end
    end
endmodule

// ### tb/tb_spd_engine.sv
// Self-checking bench for the eight-channel serial peripheral transfer engine.
`timescale 1ns/10ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_fail++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb_spd_engine;
    import spd_pkg::*;
    logic             clk, sys_rst, reg_wr, reg_rd, reg_hit, mem_req, mem_we, mem_ack;
    logic [31:0]      reg_addr, reg_wdata, reg_rdata, mem_addr, mem_wdata, mem_rdata, rd;
    logic [3:0]       item_half, rx_ready, rx_taken, tx_space, tx_load, mem_be;
    logic [3:0][15:0] rx_item;
    logic [15:0]      tx_item;
    logic [7:0]       xfer_end, xfer_done;
    logic [31:0]      base [4];
    int               n_fail, comparisons, ptr;

    spd_engine dut (.clk, .sys_rst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
        .reg_hit, .item_half, .rx_ready, .rx_item, .rx_taken, .tx_space, .tx_item, .tx_load,
        .xfer_end, .xfer_done, .mem_req, .mem_we, .mem_addr, .mem_be, .mem_wdata, .mem_ack,
        .mem_rdata);
    spd_mem_model mem (.clk, .mem_req, .mem_addr, .mem_ack, .mem_rdata);

    // Free-running 20 MHz clock.
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // Prints the counts and the verdict, then ends the run.
    task automatic wrap_up();
        $display("Counts: comparisons=%0d n_fail=%0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // Inputs always change the same small delay after a rising edge.
    task automatic tick();
        @(posedge clk);
        #2;
    endtask

    // One register write or read; read data is taken the cycle after the strobe edge.
    task automatic reg_xfer(input logic wr, input logic [31:0] a, d, output logic [31:0] q);
        tick();
        reg_addr  = a;
        reg_wdata = d;
        reg_wr    = wr;
        reg_rd    = !wr;
        tick();
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        q      = reg_rdata;
    endtask

    // Returns at the edge that samples the awaited event; a bound that runs out fails.
    task automatic wait_ev(input int w, input int p);
        for (int k = 0; k < 80; k++) begin
            @(posedge clk);
            if ((w == 0 && rx_taken[p] === 1'b1) || (w == 2 && tx_load[p] === 1'b1) ||
                (w == 1 && mem_req === 1'b1 && mem_ack === 1'b1)) return;
        end
        n_fail++;
        wrap_up();
    endtask

    // Checks one memory access of the model's current pointer.
    task automatic chk_mem(input int p, input logic we, h, input logic [15:0] it);
        logic [31:0] a;
        a = ptr;
        wait_ev(1, p);
        `CHK(mem_we, we)
        `CHK(mem_addr, a)
        `CHK(mem_be, h ? (a[1] ? BE_HALF1 : BE_HALF0) : 4'h1 << a[1:0])
        if (we) `CHK(mem_wdata, h ? {it, it} : {4{it[7:0]}})
        // Callers drive inputs next, so step off the answer edge first.
        #2;
    endtask

    // Receive then transmit on one peripheral, with the model tracking pointer and count.
    task automatic run_periph(input int p);
        logic        h;
        logic [15:0] it;
        logic [31:0] pat;
        logic [15:0] exp_it;
        int          st;
        h = $urandom % 2;
        st = h ? 2 : 1;
        item_half[p] = h;
        ptr = 32'h2000_0000 + p * 256 + (($urandom % 4) & (h ? 2 : 3));
        reg_xfer(1'b1, base[p] + OFS_RX_PTR, ptr, rd);
        reg_xfer(1'b1, base[p] + OFS_RX_CNT, 32'h3, rd);
        reg_xfer(1'b0, base[p] + OFS_RX_CNT, 32'h0, rd);
        `CHK(rd, 32'h3)
        `CHK(xfer_end[2*p], 1'b0)
        for (int i = 0; i < 3; i++) begin
            it = $urandom;
            rx_item[p] = it;
            rx_ready[p] = 1'b1;
            wait_ev(0, p);
            `CHK(rx_taken, 4'h1 << p)
            #2 rx_ready[p] = 1'b0;
            chk_mem(p, 1'b1, h, it);
            ptr += st;
        end
        @(posedge clk);
        `CHK(xfer_done[2*p], 1'b1)
        #2;
        reg_xfer(1'b0, base[p] + OFS_RX_PTR, 32'h0, rd);
        `CHK(rd, ptr)
        `CHK(xfer_end[2*p], 1'b1)
        // A peripheral that stays ready must be ignored once the count is zero.
        rx_ready[p] = 1'b1;
        repeat (8) begin
            @(posedge clk);
            `CHK(mem_req, 1'b0)
        end
        #2 rx_ready[p] = 1'b0;
        ptr = 32'h3000_0000 + p * 256 + (($urandom % 4) & (h ? 2 : 3));
        reg_xfer(1'b1, base[p] + OFS_TX_PTR, ptr, rd);
        reg_xfer(1'b1, base[p] + OFS_TX_CNT, 32'h2, rd);
        tx_space[p] = 1'b1;
        for (int i = 0; i < 2; i++) begin
            pat = {ptr[15:0] ^ 16'h5A3C, ptr[15:0] ^ 16'hC3A5};
            chk_mem(p, 1'b0, h, 16'h0);
            wait_ev(2, p);
            exp_it = h ? (ptr[1] ? pat[31:16] : pat[15:0]) : {8'h00, pat[8*ptr[1:0] +: 8]};
            `CHK(h ? tx_item : {8'h00, tx_item[7:0]}, exp_it)
            `CHK(tx_load, 4'h1 << p)
            `CHK(xfer_done[2*p+1], i == 1)
            ptr += st;
        end
        `CHK(xfer_end[2*p+1], 1'b1)
        #2 tx_space[p] = 1'b0;
    endtask

    // Main sequence: reset, reset values and decode, then every channel in turn.
    initial begin
        void'($urandom(32'ha3b282f6));
        {sys_rst, reg_wr, reg_rd, reg_addr, reg_wdata} = {3'b100, 64'h0};
        {item_half, rx_ready, rx_item, tx_space} = '0;
        n_fail = 0;
        comparisons = 0;
        base = '{BASE_USART0, BASE_USART1, BASE_USART2, BASE_SPI};
        repeat (8) @(posedge clk);
        #2 sys_rst = 1'b0;
        `CHK(xfer_end, 8'hFF)
        // A write outside every window must not reach any channel.
        reg_xfer(1'b1, 32'h0000_0030, 32'hFFFF_FFFF, rd);
        `CHK(reg_hit, 1'b0)
        for (int p = 0; p < 4; p++) begin
            reg_xfer(1'b0, base[p] + OFS_RX_PTR, 32'h0, rd);
            `CHK(rd, PTR_RST)
            `CHK(reg_hit, 1'b1)
            reg_xfer(1'b0, base[p] + OFS_TX_CNT, 32'h0, rd);
            `CHK(rd, 32'h0)
            reg_xfer(1'b0, base[p] + 32'h40, 32'h0, rd);
            `CHK(reg_hit, 1'b0)
            `CHK(rd, 32'h0)
        end
        for (int p = 0; p < 4; p++) run_periph(p);
        // A reset after the last run must clear the counts and the first transmit pointer again.
        sys_rst = 1'b1;
        repeat (2) @(posedge clk);
        #2 sys_rst = 1'b0;
        `CHK(xfer_end, 8'hFF)
        reg_xfer(1'b0, base[0] + OFS_TX_PTR, 32'h0, rd);
        `CHK(rd, PTR_RST)
        wrap_up();
    end
endmodule
